// *** src/sleep_ctl_regs.svh ***
// sleep_ctl_regs.svh: opcodes, status bit positions and timing counts of the sleep controller
// assumes a 25 MHz system clock; included by bare name from every design file that needs it
`ifndef SLEEP_CTL_REGS_SVH
`define SLEEP_CTL_REGS_SVH

// ----------------------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------------------
`define OP_WAKE 8'hAB
`define OP_RD_STATUS1 8'h05
`define OP_DEEP_SLEEP 8'hB9
`define OP_ULTRA_SLEEP 8'h79

// ----------------------------------------------------------------------------
// status byte 1 layout and reset values
// ----------------------------------------------------------------------------
`define ST1_DEEP_BIT 3
`define ST1_ULTRA_BIT 4
`define ST1_ERR_BIT 5
`define ST1_ALL_ONES 8'hFF
`define ST1_RESET 8'h00
`define JEDEC_PATTERN 4'h5

// ----------------------------------------------------------------------------
// timing: times in ns, counts derived as longest times (round down, at least one)
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define MAX_CYC(ns) ((((ns) / `CLK_PERIOD_NS) < 1) ? 1 : ((ns) / `CLK_PERIOD_NS))
`define DEEP_ENTRY_NS 3000
`define DEEP_WAKE_NS 3000
`define ULTRA_ENTRY_NS 3000
`define ULTRA_WAKE_NS 50000
`define FALLBACK_NS 1000
`define DEEP_ENTRY_CYC `MAX_CYC(`DEEP_ENTRY_NS)
`define DEEP_WAKE_CYC `MAX_CYC(`DEEP_WAKE_NS)
`define ULTRA_ENTRY_CYC `MAX_CYC(`ULTRA_ENTRY_NS)
`define ULTRA_WAKE_CYC `MAX_CYC(`ULTRA_WAKE_NS)
`define FALLBACK_CYC `MAX_CYC(`FALLBACK_NS)

`endif

// *** src/sleep_ctl_pkg.sv ***
// sleep_ctl_pkg: types shared by the sleep controller and its neighbours
// assumes nothing beyond a SystemVerilog compiler
package sleep_ctl_pkg;

	// power state of the whole device
	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_ENTER_DEEP,
		ST_DEEP,
		ST_WAKE_DEEP,
		ST_ENTER_ULTRA,
		ST_ULTRA,
		ST_WAKE_ULTRA
	} power_state_t;

	// serial interface width
	typedef enum logic [1:0] {
		MODE_SINGLE,
		MODE_QUAD,
		MODE_OCTAL
	} iface_mode_t;

endpackage

// *** src/spi_frame_rx.sv ***
// spi_frame_rx: synchronises the serial pins and frames the first byte of each command
// assumes spi mode 0 or 3 on one data line and a link clock at most an eighth of clk
`timescale 1ns/10ps
`include "sleep_ctl_regs.svh"
module spi_frame_rx (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	output logic frame_end,
	output logic cs_fall,
	output logic op_done,
	output logic [7:0] opcode,
	output logic got_opcode,
	output logic on_boundary,
	output logic sck_edge,
	output logic si_level
);
	logic cs_meta, cs_s, cs_d, sck_meta, sck_s, sck_d, si_meta, si_s;
	logic [2:0] bit_cnt_reg;
	logic [7:0] shift_reg;
	logic got_reg;
	logic sck_rise;

	// ------------------------------------------------------------------------
	// pin synchronisers: the first stage is never read
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cs_meta <= 1'b1;
			cs_s <= 1'b1;
			cs_d <= 1'b1;
			sck_meta <= 1'b0;
			sck_s <= 1'b0;
			sck_d <= 1'b0;
			si_meta <= 1'b0;
			si_s <= 1'b0;
		end else begin
			cs_meta <= cs_n;
			cs_s <= cs_meta;
			cs_d <= cs_s;
			sck_meta <= sck;
			sck_s <= sck_meta;
			sck_d <= sck_s;
			si_meta <= si;
			si_s <= si_meta;
		end
	end

	// edges seen on the synchronised pins
	assign sck_rise = sck_s & ~sck_d & ~cs_s;
	assign sck_edge = sck_s ^ sck_d;
	assign frame_end = cs_s & ~cs_d;
	assign cs_fall = ~cs_s & cs_d;
	assign si_level = si_s;

	// bit counter and shifter; only the first byte is kept, trailing bits only move the count
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bit_cnt_reg <= 3'h0;
			shift_reg <= 8'h00;
			got_reg <= 1'b0;
		end else if (cs_fall) begin
			bit_cnt_reg <= 3'h0;
			got_reg <= 1'b0;
		end else if (sck_rise) begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1;
			if (!got_reg) begin
				shift_reg <= {shift_reg[6:0], si_s};
			end
			if (bit_cnt_reg == 3'h7) begin
				got_reg <= 1'b1;
			end
		end
	end

	assign op_done = sck_rise & (bit_cnt_reg == 3'h7) & ~got_reg;
	assign opcode = got_reg ? shift_reg : {shift_reg[6:0], si_s};
	assign got_opcode = got_reg;
	assign on_boundary = (bit_cnt_reg == 3'h0);
endmodule

// *** src/jedec_reset_detect.sv ***
// jedec_reset_detect: spots four chip-select pulses carrying 0,1,0,1 with a quiet serial clock
// assumes synchronised pin events from spi_frame_rx on the same clock
`timescale 1ns/10ps
`include "sleep_ctl_regs.svh"
module jedec_reset_detect (
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_rise,
	input wire logic sck_edge,
	input wire logic si_level,
	output logic hw_reset
);
	logic [1:0] pos_reg;
	logic expect_bit;
	logic [3:0] pattern;

	assign pattern = `JEDEC_PATTERN;
	assign expect_bit = pattern[2'h3 - pos_reg];

	// any clock activity spoils the sequence, a wrong bit restarts it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pos_reg <= 2'h0;
			hw_reset <= 1'b0;
		end else begin
			hw_reset <= 1'b0;
			if (sck_edge) begin
				pos_reg <= 2'h0;
			end else if (cs_rise) begin
				if (si_level == expect_bit) begin
					pos_reg <= pos_reg + 2'h1;
					hw_reset <= (pos_reg == 2'h3);
				end else begin
					pos_reg <= (si_level == pattern[3]) ? 2'h1 : 2'h0;
				end
			end
		end
	end
endmodule

// *** src/flash_sleep_mode_control.sv ***
// flash_sleep_mode_control: deep and ultra-deep sleep state keeping of a serial flash
// assumes pins arrive asynchronously; core handshakes (pe_*, mode_wr, auto_set) are on clk
`timescale 1ns/10ps
`include "sleep_ctl_regs.svh"
module flash_sleep_mode_control
	import sleep_ctl_pkg::*;
(
	input wire logic clk,
	input wire logic resetn,
	input wire logic cs_n,
	input wire logic sck,
	input wire logic si,
	input wire logic reset_pin_n,
	input wire logic pe_busy,
	input wire logic pe_start,
	input wire logic pe_auto_kind,
	input wire logic pe_done,
	input wire logic mode_wr,
	input wire iface_mode_t mode_wr_val,
	input wire logic auto_set,
	input wire logic pe_error_in,
	input wire logic [7:0] status1_core,
	output power_state_t power_state,
	output iface_mode_t iface_mode,
	output logic auto_ultra_sleep_enable,
	output logic deep_sleep_status_flag,
	output logic ultra_sleep_status_flag,
	output logic program_erase_error_flag,
	output logic [7:0] status1_rd,
	output logic status_read_sel,
	output logic cmd_pass,
	output logic [7:0] cmd_opcode,
	output logic regs_default
);
	power_state_t state_reg;
	iface_mode_t mode_reg;
	logic [11:0] timer_reg;
	logic [11:0] fb_cnt_reg, uw_cnt_reg;
	logic auto_en_reg, auto_pending_reg;
	logic pin_meta, pin_s;
	logic fe, cs_fall, op_done, got, bnd, sck_edge, si_level, jedec_pulse;
	logic [7:0] opcode;
	logic hw_event, wake_ok, deep_ok, ultra_ok, auto_go, timer_done, ultra_entered, ultra_leave;

	// ------------------------------------------------------------------------
	// pin framing and the jedec reset detector
	// ------------------------------------------------------------------------
	spi_frame_rx u_rx (
		.clk(clk),
		.resetn(resetn),
		.cs_n(cs_n),
		.sck(sck),
		.si(si),
		.frame_end(fe),
		.cs_fall(cs_fall),
		.op_done(op_done),
		.opcode(opcode),
		.got_opcode(got),
		.on_boundary(bnd),
		.sck_edge(sck_edge),
		.si_level(si_level)
	);

	jedec_reset_detect u_jedec (
		.clk(clk),
		.resetn(resetn),
		.cs_rise(fe),
		.sck_edge(sck_edge),
		.si_level(si_level),
		.hw_reset(jedec_pulse)
	);

	// reset pin synchroniser; held low keeps the device in standby
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pin_meta <= 1'b1;
			pin_s <= 1'b1;
		end else begin
			pin_meta <= reset_pin_n;
			pin_s <= pin_meta;
		end
	end

	// ------------------------------------------------------------------------
	// command qualification at chip-select release
	// ------------------------------------------------------------------------
	assign hw_event = jedec_pulse | ~pin_s;
	assign wake_ok = fe & got & bnd & (opcode == `OP_WAKE);
	assign deep_ok = fe & got & bnd & (opcode == `OP_DEEP_SLEEP) & ~pe_busy;
	// ultra entry only needs the whole opcode; trailing bits need no boundary
	assign ultra_ok = fe & got & (opcode == `OP_ULTRA_SLEEP) & ~pe_busy;
	assign auto_go = auto_pending_reg & pe_done;
	assign timer_done = (timer_reg == 12'h000);
	assign ultra_entered = (state_reg == ST_ENTER_ULTRA) & timer_done;
	assign ultra_leave = (state_reg == ST_ULTRA) & wake_ok;

	// power state machine with its entry and wake timer
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= ST_STANDBY;
			timer_reg <= 12'h000;
		end else if (hw_event) begin
			state_reg <= ST_STANDBY;
			timer_reg <= 12'h000;
		end else begin
			timer_reg <= timer_done ? 12'h000 : timer_reg - 12'h001;
			case (state_reg)
				ST_STANDBY: begin
					if (auto_go || ultra_ok) begin
						state_reg <= ST_ENTER_ULTRA;
						timer_reg <= 12'(`ULTRA_ENTRY_CYC);
					end else if (deep_ok) begin
						state_reg <= ST_ENTER_DEEP;
						timer_reg <= 12'(`DEEP_ENTRY_CYC);
					end
				end
				ST_ENTER_DEEP: begin
					if (timer_done) begin
						state_reg <= ST_DEEP;
					end
				end
				ST_DEEP: begin // every opcode but wake and status read is dropped, ragged frames included
					if (wake_ok) begin
						state_reg <= ST_WAKE_DEEP;
						timer_reg <= 12'(`DEEP_WAKE_CYC);
					end
				end
				ST_WAKE_DEEP, ST_WAKE_ULTRA: begin
					if (timer_done) begin
						state_reg <= ST_STANDBY;
					end
				end
				ST_ENTER_ULTRA: begin
					if (timer_done) begin
						state_reg <= ST_ULTRA;
					end
				end
				ST_ULTRA: begin // chip-select activity alone is not a wake source
					if (wake_ok) begin
						state_reg <= ST_WAKE_ULTRA;
						timer_reg <= 12'(`ULTRA_WAKE_CYC);
					end
				end
				default: begin
					state_reg <= ST_STANDBY;
				end
			endcase
		end
	end

	// cycles spent waking from ultra sleep; the wake is too long for a delay range in a check
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			uw_cnt_reg <= 12'h000;
		end else begin
			uw_cnt_reg <= (state_reg == ST_WAKE_ULTRA) ? uw_cnt_reg + 12'h001 : 12'h000;
		end
	end

	// register defaults pulse on every ultra exit and hardware reset
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			regs_default <= 1'b0;
		end else begin
			regs_default <= hw_event | ((state_reg == ST_WAKE_ULTRA) & timer_done);
		end
	end

	// ------------------------------------------------------------------------
	// interface width: kept across deep sleep, forced single by ultra and auto mode
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg <= MODE_SINGLE;
		end else if (hw_event | ultra_leave) begin
			mode_reg <= MODE_SINGLE;
		end else if (fb_cnt_reg == 12'h001) begin
			mode_reg <= MODE_SINGLE;
		end else if (mode_wr && state_reg == ST_STANDBY) begin
			mode_reg <= mode_wr_val;
		end
	end

	// auto ultra bookkeeping: armed only by the listed program and erase kinds
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			auto_pending_reg <= 1'b0;
			fb_cnt_reg <= 12'h000;
		end else begin
			fb_cnt_reg <= (fb_cnt_reg == 12'h000) ? 12'h000 : fb_cnt_reg - 12'h001;
			if (hw_event || (state_reg == ST_STANDBY && (auto_go || ultra_ok || deep_ok))) begin
				auto_pending_reg <= 1'b0;
				fb_cnt_reg <= 12'h000;
			end else if (pe_start && pe_auto_kind && auto_en_reg) begin
				auto_pending_reg <= 1'b1;
				fb_cnt_reg <= 12'(`FALLBACK_CYC);
			end
		end
	end

	// enable bit: software set wins over the self-clear on entry
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			auto_en_reg <= 1'b0;
		end else if (auto_set) begin
			auto_en_reg <= 1'b1;
		end else if (ultra_entered || hw_event || ((state_reg == ST_WAKE_ULTRA) && timer_done)) begin
			auto_en_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------------------
	// status byte 1 view
	// ------------------------------------------------------------------------
	function automatic logic [7:0] build_status(input logic [7:0] core, input logic dflag, input logic uflag,
			input logic err, input logic ultra);
		logic [7:0] v;
		v = core;
		v[`ST1_DEEP_BIT] = dflag;
		v[`ST1_ULTRA_BIT] = uflag;
		v[`ST1_ERR_BIT] = err;
		build_status = ultra ? `ST1_ALL_ONES : v;
	endfunction

	// error flag is frozen in ultra sleep so it survives the exit
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			program_erase_error_flag <= 1'b0;
		end else if (state_reg != ST_ULTRA && state_reg != ST_WAKE_ULTRA && state_reg != ST_ENTER_ULTRA) begin
			program_erase_error_flag <= pe_error_in;
		end
	end

	// flags clear once standby is reached, so polling shows wake completion
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			deep_sleep_status_flag <= 1'b0;
			ultra_sleep_status_flag <= 1'b0;
			status1_rd <= `ST1_RESET;
		end else begin
			deep_sleep_status_flag <= (state_reg == ST_ENTER_DEEP) | (state_reg == ST_DEEP) |
				(state_reg == ST_WAKE_DEEP);
			ultra_sleep_status_flag <= (state_reg == ST_ENTER_ULTRA) | (state_reg == ST_ULTRA) |
				(state_reg == ST_WAKE_ULTRA);
			status1_rd <= build_status(status1_core, deep_sleep_status_flag, ultra_sleep_status_flag,
				program_erase_error_flag, state_reg == ST_ULTRA);
		end
	end

	// status read is honoured in every state; other opcodes reach the core only in standby
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			status_read_sel <= 1'b0;
			cmd_pass <= 1'b0;
			cmd_opcode <= 8'h00;
		end else begin
			cmd_pass <= op_done & (state_reg == ST_STANDBY);
			if (op_done) begin
				cmd_opcode <= opcode;
			end
			if (fe || cs_fall) begin
				status_read_sel <= 1'b0;
			end else if (op_done && opcode == `OP_RD_STATUS1) begin
				status_read_sel <= 1'b1;
			end
		end
	end

	assign power_state = state_reg;
	assign iface_mode = mode_reg;
	assign auto_ultra_sleep_enable = auto_en_reg;

	// ------------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------------
	localparam int DW_MAX = `DEEP_WAKE_CYC + 2;
	localparam int UW_MAX = `ULTRA_WAKE_CYC + 2;

	sequence s_deep_wake_start;
		$rose(state_reg == ST_WAKE_DEEP);
	endsequence
	sequence s_ultra_wake_start;
		$rose(state_reg == ST_WAKE_ULTRA);
	endsequence
	chk_deep_ignores_cmds: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_DEEP && fe && opcode != `OP_WAKE && !hw_event) |=> state_reg == ST_DEEP)
		else $error("deep sleep left on a foreign opcode");
	chk_deep_wake_time: assert property (@(posedge clk) disable iff (!resetn)
		s_deep_wake_start |-> ##[1:DW_MAX] (state_reg == ST_STANDBY && !deep_sleep_status_flag) or hw_event)
		else $error("deep sleep wake too slow");
	chk_ragged_wake: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_DEEP && fe && !bnd && !hw_event) |=> state_reg == ST_DEEP)
		else $error("ragged wake frame woke the device");
	chk_ultra_wake_time: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_WAKE_ULTRA) |-> uw_cnt_reg < 12'(UW_MAX))
		else $error("ultra sleep wake too slow");
	chk_ultra_all_ones: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_ULTRA) [*2] |-> status1_rd == `ST1_ALL_ONES)
		else $error("status in ultra sleep not all ones");
	chk_ultra_busy_ignored: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_STANDBY && ultra_ok == 1'b0 && fe && got && opcode == `OP_ULTRA_SLEEP &&
			pe_busy && !auto_go) |=> state_reg == ST_STANDBY)
		else $error("ultra command taken while busy");
	chk_auto_self_clear: assert property (@(posedge clk) disable iff (!resetn)
		($rose(state_reg == ST_ULTRA) && !$past(auto_set)) |-> !auto_ultra_sleep_enable)
		else $error("auto enable not cleared on ultra entry");
	chk_ultra_exit_single: assert property (@(posedge clk) disable iff (!resetn)
		s_ultra_wake_start |-> iface_mode == MODE_SINGLE)
		else $error("ultra exit not in single-line mode");
	chk_ultra_no_cs_wake: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_ULTRA && !wake_ok && !hw_event) |=> state_reg == ST_ULTRA)
		else $error("ultra sleep left without a wake source");
	chk_deep_keeps_mode: assert property (@(posedge clk) disable iff (!resetn)
		(state_reg == ST_DEEP && !hw_event && fb_cnt_reg != 12'h001) |=> $stable(iface_mode))
		else $error("interface width changed in deep sleep");
endmodule

// *** tb/host_spi_model.sv ***
// host_spi_model: host side of the serial pins, drives chip select, link clock and data
// assumes the bench clk at 25 MHz; link clock of 8 clk per period, still and low between frames
`timescale 1ns/10ps
module host_spi_model (
	input wire logic clk,
	output logic cs_n,
	output logic sck,
	output logic si
);
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
	end

	// ----------------------------------------------------------------------------
	// frame: n bits msb first from bits[15]; n = 0 is a bare chip-select toggle
	// ----------------------------------------------------------------------------
	task automatic frame(input logic [15:0] bits, input int n);
		@(posedge clk) cs_n <= 1'b0;
		for (int i = 0; i < n; i++) begin
			si <= bits[15 - i];
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			repeat (4) @(posedge clk);
			sck <= 1'b0;
		end
		repeat (8) @(posedge clk);
		cs_n <= 1'b1;
		si <= ~si; // a released line must not look like held data
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------------------
	// four chip-select pulses carrying 0,1,0,1 with the link clock quiet
	// ----------------------------------------------------------------------------
	task automatic jedec();
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) cs_n <= 1'b0;
			si <= i[0];
			repeat (8) @(posedge clk);
			cs_n <= 1'b1;
			repeat (8) @(posedge clk);
			si <= ~si; // data held past the rising edge, then let go
		end
	endtask
endmodule

// *** tb/flash_sleep_mode_control_tb_top.sv ***
// flash_sleep_mode_control_tb_top: self-checking bench of the sleep controller
// assumes sleep_ctl_pkg and sleep_ctl_regs.svh compiled first; design asserts live in src
`timescale 1ns/10ps
`include "sleep_ctl_regs.svh"
module flash_sleep_mode_control_tb_top
	import sleep_ctl_pkg::*;
;
	typedef struct {int sel; logic [7:0] exp;} note_t;
	logic clk, resetn, reset_pin_n, pe_busy, pe_start, pe_auto_kind, pe_done, mode_wr, auto_set, pe_error_in;
	iface_mode_t mode_wr_val, iface_mode;
	logic [7:0] status1_core, status1_rd;
	wire logic cs_n, sck, si;
	power_state_t power_state;
	logic auto_en, deep_flag, ultra_flag, err_flag, regs_default, rd_sel, pass_pulse;
	logic sel_seen = 1'b0;
	logic [7:0] last_opcode;
	logic [31:0] lfsr_reg = 32'h8693AE5F;
	int error_cnt = 0;
	int check_count = 0;
	int default_cnt = 0;
	int pass_cnt = 0;
	int sel_cnt = 0;
	note_t note_q[$];
	string sel_name[11] = '{"power_state", "iface_mode", "deep_flag", "ultra_flag", "status1_rd",
		"auto_enable", "default_count", "error_flag", "pass_count", "read_sel_count", "cmd_opcode"};

	host_spi_model u_host_spi_model (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si));
	flash_sleep_mode_control u_flash_sleep_mode_control (.clk(clk), .resetn(resetn), .cs_n(cs_n),
		.sck(sck), .si(si), .reset_pin_n(reset_pin_n), .pe_busy(pe_busy), .pe_start(pe_start),
		.pe_auto_kind(pe_auto_kind), .pe_done(pe_done), .mode_wr(mode_wr), .mode_wr_val(mode_wr_val),
		.auto_set(auto_set), .pe_error_in(pe_error_in), .status1_core(status1_core), .power_state(power_state),
		.iface_mode(iface_mode), .auto_ultra_sleep_enable(auto_en), .deep_sleep_status_flag(deep_flag),
		.ultra_sleep_status_flag(ultra_flag), .program_erase_error_flag(err_flag),
		.status1_rd(status1_rd), .status_read_sel(rd_sel), .cmd_pass(pass_pulse), .cmd_opcode(last_opcode),
		.regs_default(regs_default));

	// ----------------------------------------------------------------------------
	// clock, watchdog and scoreboard
	// ----------------------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// roughly eight times the expected run; a hang still reaches the verdict
	initial begin
		repeat (40000) @(posedge clk);
		error_cnt++;
		close_out();
	end

	always @(posedge clk) begin
		if (regs_default === 1'b1) begin
			default_cnt++;
		end
		if (pass_pulse === 1'b1) begin
			pass_cnt++;
		end
		// count each rise of the read select once, it stands for the rest of the frame
		if (rd_sel === 1'b1 && !sel_seen) begin
			sel_cnt++;
		end
		sel_seen = (rd_sel === 1'b1);
	end

	// falling edge: outputs are settled, so no race with the driver
	always @(negedge clk) begin
		note_t n;
		logic [7:0] seen;
		while (note_q.size() > 0) begin
			n = note_q.pop_front();
			case (n.sel)
				0: seen = {5'h00, power_state};
				1: seen = {6'h00, iface_mode};
				2: seen = {7'h00, deep_flag};
				3: seen = {7'h00, ultra_flag};
				4: seen = status1_rd;
				5: seen = {7'h00, auto_en};
				6: seen = default_cnt[7:0];
				8: seen = pass_cnt[7:0];
				9: seen = sel_cnt[7:0];
				10: seen = last_opcode;
				default: seen = {7'h00, err_flag};
			endcase
			check(sel_name[n.sel], seen, n.exp);
		end
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------------------
	// driver tasks
	// ----------------------------------------------------------------------------
	task automatic exp_val(input int sel, input logic [7:0] exp);
		note_q.push_back('{sel, exp});
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic rnd_step();
		lfsr_reg = lfsr_next(lfsr_reg);
		@(posedge clk) status1_core <= lfsr_reg[7:0];
	endtask

	task automatic set_mode(input iface_mode_t m);
		@(posedge clk) mode_wr <= 1'b1;
		mode_wr_val <= m;
		@(posedge clk) mode_wr <= 1'b0;
	endtask

	// ragged 11-bit frame: ultra entry asks only for a whole opcode
	task automatic go_ultra();
		rnd_step();
		u_host_spi_model.frame({`OP_ULTRA_SLEEP, lfsr_reg[7:0]}, 11);
		repeat (`ULTRA_ENTRY_CYC + 4) @(posedge clk);
		exp_val(0, ST_ULTRA);
	endtask

	task automatic wake_ultra();
		int d0;
		d0 = default_cnt;
		u_host_spi_model.frame({`OP_WAKE, 8'h00}, 8);
		repeat (`ULTRA_WAKE_CYC + 4) @(posedge clk); // host idles until standby
		exp_val(0, ST_STANDBY);
		exp_val(3, 8'h00);
		exp_val(6, 8'(d0 + 1));
		exp_val(1, MODE_SINGLE);
	endtask

	// auto-sleep run; sleep commands sent while busy must be dropped
	task automatic core_op(input logic kind);
		@(posedge clk) auto_set <= 1'b1;
		@(posedge clk) auto_set <= 1'b0;
		pe_busy <= 1'b1;
		pe_start <= 1'b1;
		pe_auto_kind <= kind;
		@(posedge clk) pe_start <= 1'b0;
		exp_val(5, 8'h01);
		repeat (`FALLBACK_CYC + 4) @(posedge clk);
		exp_val(1, kind ? MODE_SINGLE : MODE_OCTAL);
		u_host_spi_model.frame({`OP_DEEP_SLEEP, 8'h00}, 8);
		u_host_spi_model.frame({`OP_ULTRA_SLEEP, 8'h00}, 8);
		exp_val(0, ST_STANDBY);
		@(posedge clk) pe_done <= 1'b1;
		pe_busy <= 1'b0;
		@(posedge clk) pe_done <= 1'b0;
		repeat (`ULTRA_ENTRY_CYC + 6) @(posedge clk);
		exp_val(0, kind ? ST_ULTRA : ST_STANDBY);
		exp_val(5, {7'h00, ~kind});
	endtask

	// ----------------------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------------------
	initial begin
		resetn = 1'b0;
		reset_pin_n = 1'b1;
		pe_busy = 1'b0;
		pe_start = 1'b0;
		pe_auto_kind = 1'b0;
		pe_done = 1'b0;
		mode_wr = 1'b0;
		mode_wr_val = MODE_SINGLE;
		auto_set = 1'b0;
		pe_error_in = 1'b0;
		status1_core = 8'h00;
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		repeat (8) @(posedge clk); // power-up delay before any command
		exp_val(0, ST_STANDBY);
		exp_val(1, MODE_SINGLE);
		set_mode(MODE_QUAD);
		rnd_step();
		u_host_spi_model.frame({`OP_DEEP_SLEEP, lfsr_reg[7:0]}, 16);
		repeat (`DEEP_ENTRY_CYC + 4) @(posedge clk);
		exp_val(0, ST_DEEP);
		exp_val(4, {status1_core[7:6], pe_error_in, 2'b01, status1_core[2:0]});
		u_host_spi_model.frame({`OP_ULTRA_SLEEP, 8'h00}, 8);
		u_host_spi_model.frame({`OP_WAKE, lfsr_reg[7:0]}, 12);
		u_host_spi_model.frame({`OP_WAKE, 8'h00}, 5);
		repeat (`DEEP_WAKE_CYC + 4) @(posedge clk);
		exp_val(0, ST_DEEP);
		u_host_spi_model.frame({`OP_WAKE, lfsr_reg[7:0]}, 16);
		repeat (`DEEP_WAKE_CYC + 4) @(posedge clk);
		exp_val(0, ST_STANDBY);
		exp_val(2, 8'h00);
		exp_val(1, MODE_QUAD);
		u_host_spi_model.frame({`OP_ULTRA_SLEEP, 8'h00}, 5);
		repeat (`ULTRA_ENTRY_CYC + 4) @(posedge clk);
		exp_val(0, ST_STANDBY);
		set_mode(MODE_OCTAL);
		@(posedge clk) pe_error_in <= 1'b1;
		go_ultra();
		@(posedge clk) pe_error_in <= 1'b0;
		u_host_spi_model.frame(16'h0000, 0);
		u_host_spi_model.frame({`OP_RD_STATUS1, 8'h00}, 16);
		exp_val(0, ST_ULTRA);
		exp_val(4, 8'hFF);
		exp_val(3, 8'h01);
		exp_val(7, 8'h01);
		// only the deep and the 11-bit ultra frames sent in standby reach the core; the status read is still selected
		exp_val(8, 8'h02);
		exp_val(9, 8'h01);
		exp_val(10, `OP_RD_STATUS1);
		wake_ultra();
		go_ultra();
		u_host_spi_model.jedec();
		repeat (4) @(posedge clk);
		exp_val(0, ST_STANDBY);
		go_ultra();
		@(posedge clk) reset_pin_n <= 1'b0;
		repeat (6) @(posedge clk);
		reset_pin_n <= 1'b1;
		repeat (6) @(posedge clk);
		exp_val(0, ST_STANDBY);
		set_mode(MODE_OCTAL);
		core_op(1'b1);
		wake_ultra();
		set_mode(MODE_OCTAL);
		core_op(1'b0);
		repeat (4) @(posedge clk);
		close_out();
	end
endmodule
